// ---- core/wfa_consts.svh ----
`ifndef WFA_CONSTS_SVH
`define WFA_CONSTS_SVH

// ==========================================================================
// clock and timing
`define WFA_CLK_KHZ        25000
`define WFA_T_PULSE_US     100
`define WFA_T_GAP_US       100
`define WFA_T_CFG_US       7
`define WFA_T_FLT_SHORT_US 16
`define WFA_T_FLT_LONG_US  64
// microseconds to clock cycles, rounded up
`define WFA_US2CYC(t)      ((((t) * `WFA_CLK_KHZ) + 999) / 1000)

// ==========================================================================
// register indices on the plain register port
`define WFA_A_CTRL         4'h0
`define WFA_A_WAKE_EN      4'h1
`define WFA_A_WAKE_A       4'h2
`define WFA_A_WAKE_B       4'h3
`define WFA_A_LEVEL        4'h4
`define WFA_A_FAIL         4'h5
`define WFA_A_SEVERE       4'h6
`define WFA_A_IRQ_STAT     4'h7
`define WFA_A_IRQ_MASK     4'h8
`define WFA_A_CFG          4'h9

// ==========================================================================
// field positions and reset values
`define WFA_B_GLOBAL       0
`define WFA_B_FLT_LONG     1
`define WFA_E_PULSE        0
`define WFA_E_STOP         1
`define WFA_NEVT           2
`define WFA_NSEV           6
`define WFA_RST_GLOBAL     1'b0
`define WFA_RST_FLT_LONG   1'b0

`endif

// ---- core/wfa_pkg.sv ----
package wfa_pkg;

    typedef enum logic [1:0] {
        WFA_M_INIT   = 2'b00,
        WFA_M_NORMAL = 2'b01,
        WFA_M_STOP   = 2'b10,
        WFA_M_OTHER  = 2'b11
    } wfa_mode_t;

    typedef enum logic [1:0] {
        WFA_S_IDLE = 2'b00,
        WFA_S_LOW  = 2'b01,
        WFA_S_GAP  = 2'b10
    } wfa_state_t;

endpackage

// ---- core/wfa_flt_if.sv ----
interface wfa_flt_if;
    logic raw;
    logic long_sel;
    logic level;

    modport core (output raw, output long_sel, input level);
    modport filt (input raw, input long_sel, output level);
endinterface

// ---- core/wfa_filter.sv ----
module wfa_filter
    import wfa_pkg::*;
#(
    parameter int SHORT_CYC = 1,
    parameter int LONG_CYC  = 1
) (
    input wire logic clk_sys, // system clock
    input wire logic rst,     // synchronous reset, active high
    wfa_flt_if.filt  f        // raw level in, qualified level out
);
    localparam int CW = $clog2(LONG_CYC + 1);
    localparam logic [CW-1:0] SHORT_L = CW'(SHORT_CYC - 1);
    localparam logic [CW-1:0] LONG_L  = CW'(LONG_CYC - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          level;
    } wfa_flt_st_t;

    wfa_flt_st_t s;
    wfa_flt_st_t next_s;
    logic [CW-1:0] lim;

    // ======================================================================
    // level is taken over only after it has differed for the whole window
    always_comb begin
        next_s = s;
        lim = f.long_sel ? LONG_L : SHORT_L;
        if (f.raw == s.level) begin
            next_s.cnt = '0;
        end else if (s.cnt >= lim) begin
            next_s.level = f.raw;
            next_s.cnt = '0;
        end else begin
            next_s.cnt = s.cnt + CW'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign f.level = s.level;
endmodule

// ---- core/wfa_alert.sv ----
`include "wfa_consts.svh"

module wfa_alert
    import wfa_pkg::*;
#(
    parameter int NW = 4, // wake pins reported in the first wake register
    parameter int NG = 2, // general-purpose wake inputs in the second one
    parameter int NF = 8  // failure events that may alert in the global class
) (
    input  wire logic          clk_sys,     // system clock, 25 MHz
    input  wire logic          rst,         // synchronous reset, active high
    input  wire logic [3:0]    reg_addr,    // register index
    input  wire logic [31:0]   reg_wdata,   // write data
    input  wire logic          reg_wr,      // write strobe
    input  wire logic          reg_rd,      // read strobe
    output logic      [31:0]   reg_rdata,   // read data, cycle after strobe
    input  wire logic [1:0]    sys_mode,    // operating mode, same clock
    input  wire logic          stop_cmd,    // stop mode command pulse
    input  wire logic [NW+NG-1:0] wake_pin, // raw wake pins, asynchronous
    input  wire logic [NF-1:0] fail_evt,    // failure event pulses
    input  wire logic [5:0]    severe_evt,  // severe failure event pulses
    input  wire logic          alert_in,    // alert pin level, asynchronous
    output logic               alert_out,   // alert pin drive value
    output logic               alert_oe_n,  // alert pin drive enable, low drives
    output logic               cfg_level,   // configuration level from init
    output logic               irq          // interrupt, high active level
);
    localparam int NP        = NW + NG;
    localparam int PULSE_CYC = `WFA_US2CYC(`WFA_T_PULSE_US);
    localparam int GAP_CYC   = `WFA_US2CYC(`WFA_T_GAP_US);
    localparam int CW        = $clog2(PULSE_CYC + GAP_CYC);
    localparam logic [CW-1:0] PULSE_L = CW'(PULSE_CYC - 1);
    localparam logic [CW-1:0] GAP_L   = CW'(GAP_CYC - 1);

    typedef struct packed {
        wfa_state_t             st;
        logic [CW-1:0]          cnt;
        logic                   cls_global;
        logic                   flt_long;
        logic [NP-1:0]          wake_en;
        logic [NP-1:0]          lvl_q;
        logic [NP-1:0]          live_w;
        logic [NP-1:0]          view_w;
        logic [NF-1:0]          live_f;
        logic [NF-1:0]          view_f;
        logic [`WFA_NSEV-1:0]   live_s;
        logic [`WFA_NSEV-1:0]   view_s;
        logic                   pend_stop;
        logic [`WFA_NEVT-1:0]   evt;
        logic [`WFA_NEVT-1:0]   mask;
        logic                   irq;
        logic                   alert_n;
        logic                   oe_n;
        logic [NP-1:0]          sy_w1;
        logic [NP-1:0]          sy_w2;
        logic                   sy_a1;
        logic                   sy_a2;
        logic                   cfg_level;
        logic [31:0]            rdata;
    } wfa_st_t;

    wfa_st_t s;
    wfa_st_t next_s;

    logic [NP-1:0]        lvl;
    logic                 cfg_filt;
    logic                 run;
    logic                 want;
    logic                 start;
    logic [NP-1:0]        clr_w;
    logic [NF-1:0]        clr_f;
    logic [`WFA_NSEV-1:0] clr_s;
    logic [`WFA_NEVT-1:0] clr_e;
    logic [`WFA_NEVT-1:0] set_e;
    logic [NP-1:0]        wake_rise;

    // ======================================================================
    // input filters
    genvar g;
    generate
        for (g = 0; g < NP; g++) begin : g_flt
            wfa_flt_if fi ();
            assign fi.raw      = s.sy_w2[g];
            assign fi.long_sel = s.flt_long;
            assign lvl[g]      = fi.level;
            wfa_filter #(
                .SHORT_CYC (`WFA_US2CYC(`WFA_T_FLT_SHORT_US)),
                .LONG_CYC  (`WFA_US2CYC(`WFA_T_FLT_LONG_US))
            ) u_flt (
                .clk_sys (clk_sys),
                .rst     (rst),
                .f       (fi)
            );
        end
    endgenerate

    wfa_flt_if cfg_if ();
    assign cfg_if.raw      = s.sy_a2;
    assign cfg_if.long_sel = 1'b0;
    assign cfg_filt        = cfg_if.level;

    wfa_filter #(
        .SHORT_CYC (`WFA_US2CYC(`WFA_T_CFG_US)),
        .LONG_CYC  (`WFA_US2CYC(`WFA_T_CFG_US))
    ) u_cfg_flt (
        .clk_sys (clk_sys),
        .rst     (rst),
        .f       (cfg_if)
    );

    // ======================================================================
    // next state
    always_comb begin
        next_s = s;
        clr_w = '0;
        clr_f = '0;
        clr_s = '0;
        clr_e = '0;
        set_e = '0;
        start = 1'b0;

        next_s.sy_w1 = wake_pin;
        next_s.sy_w2 = s.sy_w1;
        next_s.sy_a1 = alert_in;
        next_s.sy_a2 = s.sy_a1;
        next_s.lvl_q = lvl;

        // register writes
        if (reg_wr) begin
            case (reg_addr)
                `WFA_A_CTRL: begin
                    next_s.cls_global = reg_wdata[`WFA_B_GLOBAL];
                    next_s.flt_long   = reg_wdata[`WFA_B_FLT_LONG];
                end
                `WFA_A_WAKE_EN: begin
                    next_s.wake_en = reg_wdata[NP-1:0];
                end
                `WFA_A_WAKE_A: begin
                    clr_w[NW-1:0] = reg_wdata[NW-1:0];
                end
                `WFA_A_WAKE_B: begin
                    clr_w[NP-1:NW] = reg_wdata[NG-1:0];
                end
                `WFA_A_FAIL: begin
                    clr_f = reg_wdata[NF-1:0];
                end
                `WFA_A_SEVERE: begin
                    clr_s = reg_wdata[`WFA_NSEV-1:0];
                end
                `WFA_A_IRQ_STAT: begin
                    clr_e = reg_wdata[`WFA_NEVT-1:0];
                end
                `WFA_A_IRQ_MASK: begin
                    next_s.mask = reg_wdata[`WFA_NEVT-1:0];
                end
                default: begin
                end
            endcase
        end

        // sticky event flags, a new event wins over a clear
        wake_rise = lvl & ~s.lvl_q & s.wake_en;
        next_s.live_w = (s.live_w & ~clr_w) | wake_rise;
        next_s.view_w = s.view_w & ~clr_w;
        next_s.live_f = (s.live_f & ~clr_f) | fail_evt;
        next_s.view_f = s.view_f & ~clr_f;
        next_s.live_s = (s.live_s & ~clr_s) | severe_evt;
        next_s.view_s = s.view_s & ~clr_s;

        // severe flags never feed the alert; the level register is not latched
        run  = (sys_mode == WFA_M_NORMAL) || (sys_mode == WFA_M_STOP);
        want = (|(s.live_w & ~s.view_w))
             | (s.cls_global & (|(s.live_f & ~s.view_f)))
             | s.pend_stop;

        // pulse and gap sequencing
        case (s.st)
            WFA_S_IDLE: begin
                if (run && want) begin
                    start = 1'b1;
                    next_s.st = WFA_S_LOW;
                    next_s.cnt = PULSE_L;
                end
            end
            WFA_S_LOW: begin
                if (s.cnt == '0) begin
                    next_s.st = WFA_S_GAP;
                    next_s.cnt = GAP_L;
                end else begin
                    next_s.cnt = s.cnt - CW'(1);
                end
            end
            WFA_S_GAP: begin
                if (s.cnt == '0) begin
                    next_s.st = WFA_S_IDLE;
                end else begin
                    next_s.cnt = s.cnt - CW'(1);
                end
            end
            default: begin
                next_s.st = WFA_S_IDLE;
                next_s.cnt = '0;
            end
        endcase

        if (!run) begin
            next_s.st = WFA_S_IDLE;
            next_s.cnt = '0;
        end

        // readable copies taken at the falling edge of the pin
        if (start) begin
            next_s.view_w = next_s.live_w;
            next_s.view_f = next_s.live_f;
            next_s.view_s = next_s.live_s;
            next_s.pend_stop = 1'b0;
            set_e[`WFA_E_PULSE] = 1'b1;
        end

        if (stop_cmd && (|next_s.live_w)) begin
            next_s.pend_stop = 1'b1;
            set_e[`WFA_E_STOP] = 1'b1;
        end

        next_s.evt = (s.evt & ~clr_e) | set_e;
        next_s.irq = |(next_s.evt & next_s.mask);

        // pin drive: released for sampling in init, else driven
        if (sys_mode == WFA_M_INIT) begin
            next_s.oe_n = 1'b1;
            next_s.alert_n = 1'b1;
            next_s.cfg_level = cfg_filt;
        end else begin
            next_s.oe_n = 1'b0;
            next_s.alert_n = (next_s.st != WFA_S_LOW);
        end

        // register reads
        next_s.rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                `WFA_A_CTRL: begin
                    next_s.rdata[`WFA_B_GLOBAL]   = s.cls_global;
                    next_s.rdata[`WFA_B_FLT_LONG] = s.flt_long;
                end
                `WFA_A_WAKE_EN: begin
                    next_s.rdata = 32'(s.wake_en);
                end
                `WFA_A_WAKE_A: begin
                    next_s.rdata = 32'(s.view_w[NW-1:0]);
                end
                `WFA_A_WAKE_B: begin
                    next_s.rdata = 32'(s.view_w[NP-1:NW]);
                end
                `WFA_A_LEVEL: begin
                    next_s.rdata = 32'(lvl);
                end
                `WFA_A_FAIL: begin
                    next_s.rdata = 32'(s.view_f);
                end
                `WFA_A_SEVERE: begin
                    next_s.rdata = 32'(s.view_s);
                end
                `WFA_A_IRQ_STAT: begin
                    next_s.rdata = 32'(s.evt);
                end
                `WFA_A_IRQ_MASK: begin
                    next_s.rdata = 32'(s.mask);
                end
                `WFA_A_CFG: begin
                    next_s.rdata = 32'(s.cfg_level);
                end
                default: begin
                    next_s.rdata = '0;
                end
            endcase
        end
    end

    // ======================================================================
    // state register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s <= '0;
            s.st <= WFA_S_IDLE;
            s.cls_global <= `WFA_RST_GLOBAL;
            s.flt_long <= `WFA_RST_FLT_LONG;
            s.alert_n <= 1'b1;
            s.oe_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign reg_rdata  = s.rdata;
    assign alert_out  = s.alert_n;
    assign alert_oe_n = s.oe_n;
    assign cfg_level  = s.cfg_level;
    assign irq        = s.irq;
endmodule

// ---- tb/wfa_alert_asserts.sv ----
module wfa_alert_asserts
    import wfa_pkg::*;
(
    input wire logic       clk_sys,    // system clock
    input wire logic       rst,        // sync reset
    input wire logic [1:0] sys_mode,   // operating mode
    input wire logic       alert_in,   // pin level
    input wire logic       alert_out,  // pin drive value
    input wire logic       alert_oe_n, // pin drive enable
    input wire logic       cfg_level   // captured config
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // ==================================================
    // run-length counters of the pin drive value and of the pin level in init
    logic [11:0] low_cnt;
    logic [11:0] hi_cnt;
    logic [7:0]  stab;
    logic        in_q;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            low_cnt <= 12'h000;
            hi_cnt  <= 12'h9c4;
            stab    <= 8'h00;
            in_q    <= 1'b0;
        end else begin
            low_cnt <= alert_out ? 12'h000 : low_cnt + 12'h001;
            hi_cnt  <= !alert_out ? 12'h000 : (hi_cnt == 12'hfff ? hi_cnt : hi_cnt + 12'h001);
            in_q    <= alert_in;
            if (sys_mode == WFA_M_INIT && alert_in == in_q) begin
                stab <= (stab == 8'hff) ? stab : stab + 8'h01;
            end else begin
                stab <= 8'h00;
            end
        end
    end

    // ==================================================
    // checks
    sequence s_release;
        $rose(alert_out) ##0 $past(sys_mode) inside {WFA_M_NORMAL, WFA_M_STOP};
    endsequence

    AST_PULSE_LEN: assert property (s_release |-> low_cnt == 12'h9c4)
        else $error("alert pulse length wrong");
    AST_PULSE_MAX: assert property (low_cnt <= 12'h9c4)
        else $error("alert pulse too long");
    AST_PULSE_MODE: assert property ($fell(alert_out) |-> $past(sys_mode) inside
        {WFA_M_NORMAL, WFA_M_STOP})
        else $error("alert pulse outside normal or stop");
    AST_GAP: assert property ($fell(alert_out) |-> hi_cnt >= 12'h9c4)
        else $error("gap between pulses too short");
    AST_ABORT: assert property (sys_mode inside {WFA_M_INIT, WFA_M_OTHER} |=> alert_out)
        else $error("alert low outside normal or stop");
    AST_INIT_OE: assert property (sys_mode == WFA_M_INIT |=> alert_oe_n)
        else $error("pin driven in init");
    AST_DRIVE: assert property (sys_mode != WFA_M_INIT |=> !alert_oe_n)
        else $error("pin not driven after init");
    AST_CFG: assert property (sys_mode == WFA_M_INIT && stab == 8'hc8 |->
        cfg_level == alert_in)
        else $error("config level does not follow pin");
endmodule

bind wfa_alert wfa_alert_asserts chk_i (
    .clk_sys(clk_sys),
    .rst(rst),
    .sys_mode(sys_mode),
    .alert_in(alert_in),
    .alert_out(alert_out),
    .alert_oe_n(alert_oe_n),
    .cfg_level(cfg_level)
);

// ---- tb/wfa_host.sv ----
module wfa_host (
    input  wire logic clk_sys,    // system clock
    input  wire logic alert_out,  // device drive value
    input  wire logic alert_oe_n, // device drive enable
    input  wire logic cfg_en,     // host straps the pin
    input  wire logic cfg_val,    // strap level
    output logic      pin         // resolved pin level
);
    timeunit 1ns;
    timeprecision 1ps;
    // the config pull-down holds an undriven pin low
    assign pin = !alert_oe_n ? alert_out : (cfg_en ? cfg_val : 1'b0);
endmodule

// ---- tb/tb_top.sv ----
`include "wfa_consts.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end

module tb_top
    import wfa_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_sys, rst, reg_wr, reg_rd, stop_cmd, alert_in;
    logic        alert_out, alert_oe_n, cfg_level, irq, cfg_en, cfg_val;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, v;
    logic [1:0]  sys_mode;
    logic [5:0]  wake_pin, severe_evt;
    logic [7:0]  fail_evt;
    int          num_errors, num_checks, n;

    wfa_alert wfa_alert_i (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sys_mode(sys_mode), .stop_cmd(stop_cmd), .wake_pin(wake_pin), .fail_evt(fail_evt),
        .severe_evt(severe_evt), .alert_in(alert_in), .alert_out(alert_out),
        .alert_oe_n(alert_oe_n), .cfg_level(cfg_level), .irq(irq));
    wfa_host wfa_host_i (.clk_sys(clk_sys), .alert_out(alert_out), .alert_oe_n(alert_oe_n),
        .cfg_en(cfg_en), .cfg_val(cfg_val), .pin(alert_in));

    task automatic idle(input int k);
        repeat (k) @(negedge clk_sys);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask
    task automatic wait_lvl(input logic lvl, input int max, output int k);
        k = 0;
        while (alert_out !== lvl && k < max) begin
            @(negedge clk_sys);
            k++;
        end
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic t_init;
        cfg_val <= 1'b1;
        idle(250);
        `CHK(cfg_level, 1'b1)
        `CHK(alert_oe_n, 1'b1)
        cfg_val <= 1'b0;
        idle(250);
        `CHK(cfg_level, 1'b0)
        @(posedge clk_sys);
        cfg_en   <= 1'b0;
        sys_mode <= WFA_M_NORMAL;
        rd(`WFA_A_CTRL, v);
        `CHK(v, 32'h0)
        wr(4'hf, 32'hffff_ffff);
        rd(4'hf, v);
        `CHK(v, 32'h0)
    endtask

    task automatic t_wake;
        wr(`WFA_A_WAKE_EN, 32'h3f);
        wr(`WFA_A_IRQ_MASK, 32'h1);
        wake_pin <= 6'h01;
        idle(1);
        wait_lvl(1'b0, 600, n);
        `CHK(n inside {[400:409]}, 1'b1)
        wait_lvl(1'b1, 3000, n);
        `CHK(n, 2500)
        @(posedge clk_sys);
        wake_pin <= 6'h00;
        rd(`WFA_A_WAKE_A, v);
        `CHK(v, 32'h1)
        `CHK(irq, 1'b1)
        wr(`WFA_A_IRQ_MASK, 32'h0);
        idle(2);
        `CHK(irq, 1'b0)
        wr(`WFA_A_IRQ_MASK, 32'h1);
        wr(`WFA_A_IRQ_STAT, 32'h3);
        idle(2);
        `CHK(irq, 1'b0)
        rd(`WFA_A_WAKE_A, v);
        `CHK(v, 32'h1)
        wr(`WFA_A_WAKE_A, 32'h1);
        rd(`WFA_A_WAKE_A, v);
        `CHK(v, 32'h0)
        rd(`WFA_A_WAKE_A, v);
        `CHK(v, 32'h0)
        wr(`WFA_A_CTRL, 32'h2);
        idle(2600);
        @(posedge clk_sys);
        wake_pin <= 6'h02;
        idle(1);
        wait_lvl(1'b0, 2000, n);
        `CHK(n inside {[1600:1609]}, 1'b1)
        @(posedge clk_sys);
        wake_pin <= 6'h00;
        wr(`WFA_A_WAKE_A, 32'h3f);
        idle(5100);
    endtask

    task automatic t_class;
        wr(`WFA_A_CTRL, 32'h0);
        fail_evt <= 8'h01;
        @(posedge clk_sys);
        fail_evt <= 8'h00;
        idle(1);
        wait_lvl(1'b0, 3000, n);
        `CHK(alert_out, 1'b1)
        wr(`WFA_A_FAIL, 32'hff);
        wr(`WFA_A_CTRL, 32'h1);
        severe_evt <= 6'h3f;
        @(posedge clk_sys);
        severe_evt <= 6'h00;
        idle(1);
        wait_lvl(1'b0, 3000, n);
        `CHK(alert_out, 1'b1)
        @(posedge clk_sys);
        fail_evt <= 8'h02;
        @(posedge clk_sys);
        fail_evt <= 8'h00;
        idle(1);
        wait_lvl(1'b0, 5, n);
        `CHK(alert_out, 1'b0)
        idle(100);
        @(posedge clk_sys);
        fail_evt <= 8'h04;
        @(posedge clk_sys);
        fail_evt <= 8'h00;
        idle(1);
        wait_lvl(1'b1, 3000, n);
        wait_lvl(1'b0, 3000, n);
        `CHK(n inside {[2500:2502]}, 1'b1)
        rd(`WFA_A_FAIL, v);
        `CHK(v, 32'h6)
        wr(`WFA_A_FAIL, 32'hff);
        idle(5100);
    endtask

    task automatic t_stop;
        @(posedge clk_sys);
        wake_pin <= 6'h04;
        idle(1);
        wait_lvl(1'b0, 600, n);
        `CHK(alert_out, 1'b0)
        idle(5100);
        @(posedge clk_sys);
        stop_cmd <= 1'b1;
        sys_mode <= WFA_M_STOP;
        @(posedge clk_sys);
        stop_cmd <= 1'b0;
        idle(1);
        wait_lvl(1'b0, 5, n);
        `CHK(alert_out, 1'b0)
        wait_lvl(1'b1, 3000, n);
        @(posedge clk_sys);
        sys_mode <= WFA_M_OTHER;
        idle(3);
        `CHK(alert_out, 1'b1)
        `CHK(alert_oe_n, 1'b0)
        rd(`WFA_A_LEVEL, v);
        `CHK(v, 32'h4)
        rd(`WFA_A_WAKE_A, v);
        `CHK(v, 32'h4)
        rd(`WFA_A_IRQ_STAT, v);
        `CHK(v, 32'h3)
        @(posedge clk_sys);
        wake_pin <= 6'h00;
        idle(410);
        rd(`WFA_A_LEVEL, v);
        `CHK(v, 32'h0)
        rd(`WFA_A_WAKE_A, v);
        `CHK(v, 32'h4)
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (60000) @(posedge clk_sys);
        num_errors++;
        summarize();
    end

    initial begin
        num_errors = 0;
        num_checks = 0;
        rst        = 1'b1;
        reg_addr   = 4'h0;
        reg_wdata  = 32'h0;
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        sys_mode   = WFA_M_INIT;
        stop_cmd   = 1'b0;
        wake_pin   = 6'h00;
        fail_evt   = 8'h00;
        severe_evt = 6'h00;
        cfg_en     = 1'b1;
        cfg_val    = 1'b0;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        t_init();
        t_wake();
        t_class();
        t_stop();
        summarize();
    end
endmodule
